// File: verilog/rtc_counter_defines.svh
// ============================================================
// Register indices, field positions, reset values and timing
// for the real-time counter core.
// Assumes byte registers, each in one 32-bit word at 4 x index.
// ============================================================
// What this block does
// - Prescale timebase by two to field power
// - Control applies two ticks later, busy meanwhile
// - Standby-run bit chooses stop or run standby
// - Enable bit starts and stops counting
// - Status shows compare, wrap, count, control busy
// - Interrupt enables: compare bit 1, wrap 0
// - Count equal wrap limit wraps to zero
// - Compare flag set on match, one clears
// - Wrap flag set on wrap, one clears
// - One shared scratch byte for 16-bit access
// - Debug halt stops counting unless keep-running
// - Two-bit source select picks the timebase
// - Count low byte at base, high plus one
// - Enabled counter emits wrap and compare events
// - Interrupt asserted while flag and enable set
// - Counter keeps running in idle sleep
`ifndef RTC_COUNTER_DEFINES_SVH
`define RTC_COUNTER_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_CONTROL      4'h0
`define IDX_STATUS       4'h1
`define IDX_IRQ_ENABLE   4'h2
`define IDX_IRQ_FLAGS    4'h3
`define IDX_SCRATCH      4'h4
`define IDX_DEBUG        4'h5
`define IDX_SOURCE       4'h7
`define IDX_RESERVED     4'h6
`define IDX_COUNT_LO     4'h8
`define IDX_COUNT_HI     4'h9
`define IDX_WRAP_LO      4'hA
`define IDX_WRAP_HI      4'hB
`define IDX_COMPARE_LO   4'hC
`define IDX_COMPARE_HI   4'hD

// Field positions
`define CTRL_ENABLE_BIT  0
`define CTRL_PRESC_LSB   3
`define CTRL_PRESC_MSB   6
`define CTRL_STDBY_BIT   7
`define FLAG_WRAP_BIT    0
`define FLAG_CMP_BIT     1
// Control bits that hold a value; bits 2:1 always read zero
`define CTRL_WR_MASK     8'hF9

// Sync-busy slot numbers in the status byte
`define SYNC_CTRL        0
`define SYNC_COUNT       1
`define SYNC_WRAP        2
`define SYNC_COMPARE     3

// Reset values
`define RST_BYTE         8'h00
`define RST_COUNT        16'h0000
`define RST_WRAP         16'hFFFF
`define RST_COMPARE      16'h0000

// Timebase ticks from a write until it takes effect
`define SYNC_TICKS       2'h2

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// File: verilog/rtc_counter_pkg.sv
// ============================================================
// Types shared by the real-time counter core.
// Assumes the defines header is included where needed.
// ============================================================
package rtc_counter_pkg;

  // Control byte as seen by the counting logic
  typedef struct packed {
    logic       standby_run;
    logic [3:0] presc;
    logic [1:0] rsvd;
    logic       counter_enable;
  } control_main_s;

  // Timebase source codes
  typedef enum logic [1:0] {
    SRC_ULP_32K,
    SRC_ULP_1K,
    SRC_CRYSTAL,
    SRC_EXT_PIN
  } timebase_source_e;

endpackage : rtc_counter_pkg

// File: verilog/rtc_counter_core.sv
// ============================================================
// Real-time counter core with AXI4-Lite byte registers.
// Assumes timebase sources arrive as one-cycle enables on aclk
// and sleep and debug status as synchronous levels.
// ============================================================
`timescale 1ns/10ps
`include "rtc_counter_defines.svh"

module rtc_counter_core
  import rtc_counter_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              ulp_32k_tick,
  input  wire logic              ulp_1k_tick,
  input  wire logic              crystal_tick,
  input  wire logic              ext_pin_tick,
  input  wire logic              standby_sleep,
  input  wire logic              debug_halt,
  output logic                   irq,
  output logic                   wrap_event,
  output logic                   compare_event
);

  // ==========================================================
  // Functions
  // ==========================================================
  // Word index of a byte address; low two bits are ignored
  function automatic logic [3:0] reg_index(
    input logic [ADDR_W-1:0] addr);
    reg_index = addr[5:2];
  endfunction : reg_index

  // Index holds a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[ADDR_W-1:2] <= `IDX_COMPARE_HI) &&
                (a[5:2] != `IDX_RESERVED);
  endfunction : is_mapped

  // ==========================================================
  // State
  // ==========================================================
  logic             awready_ff, wready_ff, bvalid_ff, arready_ff;
  logic             rvalid_ff;
  logic [1:0]       bresp_ff, rresp_ff;
  logic [31:0]      rdata_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [7:0]       w_data_ff;
  logic             w_lane_ff;
  control_main_s    ctrl_sw_ff, ctrl_act_ff;
  logic [1:0]       irq_en_ff, irq_flags_ff;
  logic [7:0]       scratch_ff;
  logic             keep_run_ff;
  timebase_source_e src_ff;
  logic [15:0]      count_ff, cnt_sw_ff;
  logic [15:0]      wrap_sw_ff, wrap_act_ff;
  logic [15:0]      cmp_sw_ff, cmp_act_ff;
  logic [1:0]       sync_ff [4];
  logic [14:0]      presc_ff;
  logic             irq_ff, wrap_evt_ff, cmp_evt_ff;

  logic             wr_go, wr_en, ar_hs;
  logic [3:0]       wr_idx, rd_idx;
  logic [3:0]       sync_start, sync_apply, busy;
  logic             tb_tick, run, cnt_step, wrap_hit, cmp_hit;
  logic [14:0]      presc_mask;
  logic [15:0]      nxt_count;
  logic [7:0]       rd_byte;

  // ==========================================================
  // Bus slave
  // ==========================================================
  // Address and data latch independently; ready low means held
  assign wr_go  = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_en  = wr_go && w_lane_ff;   // Only byte lane 0 counts
  assign wr_idx = reg_index(aw_addr_ff);
  assign ar_hs  = arvalid && arready_ff;
  assign rd_idx = reg_index(araddr);

  // Write address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_addr_ff <= '0;
      w_data_ff  <= `RST_BYTE;
      w_lane_ff  <= 1'b0;
    end else begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_data_ff <= wdata[7:0];
        w_lane_ff <= wstrb[0];
      end
      if (wr_go) begin
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(aw_addr_ff) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read mux; high bytes come from the scratch latch
  always_comb begin
    rd_byte = `RST_BYTE;
    case (rd_idx)
      `IDX_CONTROL:    rd_byte = ctrl_sw_ff;
      `IDX_STATUS:     rd_byte = {4'h0, busy};
      `IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_en_ff};
      `IDX_IRQ_FLAGS:  rd_byte = {6'h00, irq_flags_ff};
      `IDX_SCRATCH:    rd_byte = scratch_ff;
      `IDX_DEBUG:      rd_byte = {7'h00, keep_run_ff};
      `IDX_SOURCE:     rd_byte = {6'h00, src_ff};
      `IDX_COUNT_LO:   rd_byte = count_ff[7:0];
      `IDX_WRAP_LO:    rd_byte = wrap_sw_ff[7:0];
      `IDX_COMPARE_LO: rd_byte = cmp_sw_ff[7:0];
      `IDX_COUNT_HI,
      `IDX_WRAP_HI,
      `IDX_COMPARE_HI: rd_byte = scratch_ff;
      default:         rd_byte = `RST_BYTE;
    endcase
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= `RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= {24'h000000, rd_byte};
      rresp_ff   <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Software-side registers
  // ==========================================================
  // Plain settings take effect at once; control only reaches the counter after its sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_sw_ff  <= `RST_BYTE;
      irq_en_ff   <= 2'h0;
      keep_run_ff <= 1'b0;
      src_ff      <= SRC_ULP_32K;
    end else if (wr_en) begin
      case (wr_idx)
        `IDX_CONTROL:    ctrl_sw_ff  <= w_data_ff & `CTRL_WR_MASK;
        `IDX_IRQ_ENABLE: irq_en_ff   <= w_data_ff[1:0];
        `IDX_DEBUG:      keep_run_ff <= w_data_ff[0];
        `IDX_SOURCE:     src_ff      <= timebase_source_e'(w_data_ff[1:0]);
        default:         ;
      endcase
    end
  end

  // Scratch latch: written by low bytes, loaded by low-byte reads.
  // A write in the same cycle as a read wins the latch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scratch_ff <= `RST_BYTE;
    end else if (wr_en && (wr_idx == `IDX_SCRATCH ||
                           wr_idx == `IDX_COUNT_LO ||
                           wr_idx == `IDX_WRAP_LO ||
                           wr_idx == `IDX_COMPARE_LO)) begin
      scratch_ff <= w_data_ff;
    end else if (ar_hs) begin
      case (rd_idx)
        `IDX_COUNT_LO:   scratch_ff <= count_ff[15:8];
        `IDX_WRAP_LO:    scratch_ff <= wrap_sw_ff[15:8];
        `IDX_COMPARE_LO: scratch_ff <= cmp_sw_ff[15:8];
        default:         ;
      endcase
    end
  end

  // High-byte write commits the whole 16-bit word at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_sw_ff  <= `RST_COUNT;
      wrap_sw_ff <= `RST_WRAP;
      cmp_sw_ff  <= `RST_COMPARE;
    end else if (wr_en) begin
      case (wr_idx)
        `IDX_COUNT_HI:   cnt_sw_ff  <= {w_data_ff, scratch_ff};
        `IDX_WRAP_HI:    wrap_sw_ff <= {w_data_ff, scratch_ff};
        `IDX_COMPARE_HI: cmp_sw_ff  <= {w_data_ff, scratch_ff};
        default:         ;
      endcase
    end
  end

  // ==========================================================
  // Synchronisation into the timebase
  // ==========================================================
  // Selected timebase tick
  always_comb begin
    case (src_ff)
      SRC_ULP_32K: tb_tick = ulp_32k_tick;
      SRC_ULP_1K:  tb_tick = ulp_1k_tick;
      SRC_CRYSTAL: tb_tick = crystal_tick;
      SRC_EXT_PIN: tb_tick = ext_pin_tick;
      default:     tb_tick = 1'b0;
    endcase
  end

  assign sync_start[`SYNC_CTRL]    = wr_en && wr_idx == `IDX_CONTROL;
  assign sync_start[`SYNC_COUNT]   = wr_en && wr_idx == `IDX_COUNT_HI;
  assign sync_start[`SYNC_WRAP]    = wr_en && wr_idx == `IDX_WRAP_HI;
  assign sync_start[`SYNC_COMPARE] = wr_en && wr_idx == `IDX_COMPARE_HI;

  // Each slot counts two timebase ticks; a stopped source keeps
  // the busy bit set, which software must watch for.
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        sync_ff[i] <= 2'h0;
      end else if (sync_start[i]) begin
        sync_ff[i] <= `SYNC_TICKS;
      end else if (tb_tick && sync_ff[i] != 2'h0) begin
        sync_ff[i] <= sync_ff[i] - 2'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      busy[i]       = sync_ff[i] != 2'h0;
      sync_apply[i] = tb_tick && sync_ff[i] == 2'h1;
    end
  end

  // Active copies used by the counting logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_act_ff <= `RST_BYTE;
      wrap_act_ff <= `RST_WRAP;
      cmp_act_ff  <= `RST_COMPARE;
    end else begin
      if (sync_apply[`SYNC_CTRL])
        ctrl_act_ff <= ctrl_sw_ff;
      if (sync_apply[`SYNC_WRAP])
        wrap_act_ff <= wrap_sw_ff;
      if (sync_apply[`SYNC_COMPARE])
        cmp_act_ff  <= cmp_sw_ff;
    end
  end

  // ==========================================================
  // Counting
  // ==========================================================
  // Idle sleep is not an input: the counter never stops for it
  assign run = ctrl_act_ff.counter_enable &&
               !(standby_sleep && !ctrl_act_ff.standby_run) &&
               !(debug_halt && !keep_run_ff);

  assign presc_mask = 15'((16'h0001 << ctrl_act_ff.presc) - 16'h0001);
  assign cnt_step   = tb_tick && run &&
                      ((presc_ff & presc_mask) == presc_mask);
  assign wrap_hit   = cnt_step && count_ff == wrap_act_ff;
  assign nxt_count  = wrap_hit ? `RST_COUNT : count_ff + 16'h0001;
  assign cmp_hit    = cnt_step && nxt_count == cmp_act_ff;

  // Prescaler runs on timebase ticks only while counting
  always_ff @(posedge aclk) begin
    if (!aresetn)
      presc_ff <= '0;
    else if (tb_tick && run)
      presc_ff <= presc_ff + 15'h0001;
  end

  // A synchronised count write replaces the step of that tick
  always_ff @(posedge aclk) begin
    if (!aresetn)
      count_ff <= `RST_COUNT;
    else if (sync_apply[`SYNC_COUNT])
      count_ff <= cnt_sw_ff;
    else if (cnt_step)
      count_ff <= nxt_count;
  end

  // Flags: a hardware set beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flags_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `FLAG_WRAP_BIT) ? wrap_hit : cmp_hit)
          irq_flags_ff[i] <= 1'b1;
        else if (wr_en && wr_idx == `IDX_IRQ_FLAGS && w_data_ff[i])
          irq_flags_ff[i] <= 1'b0;
      end
    end
  end

  // Event pulses and interrupt request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_evt_ff <= 1'b0;
      cmp_evt_ff  <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      wrap_evt_ff <= wrap_hit;
      cmp_evt_ff  <= cmp_hit;
      irq_ff      <= |(irq_flags_ff & irq_en_ff);
    end
  end

  assign awready       = awready_ff;
  assign wready        = wready_ff;
  assign bvalid        = bvalid_ff;
  assign bresp         = bresp_ff;
  assign arready       = arready_ff;
  assign rvalid        = rvalid_ff;
  assign rdata         = rdata_ff;
  assign rresp         = rresp_ff;
  assign irq           = irq_ff;
  assign wrap_event    = wrap_evt_ff;
  assign compare_event = cmp_evt_ff;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ctrl_write_s;
    wr_en && wr_idx == `IDX_CONTROL;
  endsequence

  a_ctrl_busy_set: assert property (ctrl_write_s |=>
      busy[`SYNC_CTRL])
    else $error("control busy not set after write");
  a_ctrl_applied: assert property ($fell(busy[`SYNC_CTRL]) |->
      ctrl_act_ff == ctrl_sw_ff)
    else $error("control not applied when busy cleared");
  a_wrap_zero: assert property (wrap_hit && !busy[`SYNC_COUNT]
      |=> count_ff == `RST_COUNT)
    else $error("count did not wrap to zero");
  a_count_step: assert property (cnt_step && !wrap_hit &&
      !sync_apply[`SYNC_COUNT] |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("count did not step by one");
  // Stopped counter: the count register itself must hold
  a_disabled_hold: assert property (
      !ctrl_act_ff.counter_enable && !sync_apply[`SYNC_COUNT] |=>
      $stable(count_ff))
    else $error("counted while disabled");
  a_standby_stop: assert property (
      standby_sleep && !ctrl_act_ff.standby_run &&
      !sync_apply[`SYNC_COUNT] |=> $stable(count_ff))
    else $error("counted in standby");
  a_debug_stop: assert property (debug_halt && !keep_run_ff
      && !sync_apply[`SYNC_COUNT] |=> $stable(count_ff))
    else $error("counted during debug halt");
  // After a step the prescaler's low bits must have rolled over
  a_presc_gate: assert property (cnt_step &&
      !sync_apply[`SYNC_CTRL] |=> (presc_ff & presc_mask) == 15'h0000)
    else $error("step off the prescaler boundary");
  a_wrap_flag: assert property (wrap_evt_ff |->
      irq_flags_ff[`FLAG_WRAP_BIT])
    else $error("wrap event without flag");
  a_cmp_flag: assert property (cmp_evt_ff |->
      irq_flags_ff[`FLAG_CMP_BIT])
    else $error("compare event without flag");
  a_irq_follow: assert property ((irq_flags_ff & irq_en_ff)
      != 2'h0 |=> irq)
    else $error("interrupt not raised");

endmodule : rtc_counter_core

// File: bench/tb_rtc_counter_core.sv
// ======================================================================
// Self-checking bench for the real-time counter core.
// Assumes the core's AXI4-Lite slave on aclk and tick enables per source.
// ======================================================================
`timescale 1ns/10ps
`include "rtc_counter_defines.svh"

module tb_rtc_counter_core;
  import rtc_counter_pkg::*;

  logic        aclk, aresetn;
  logic [5:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, tk;
  logic [1:0]  bresp, rresp;
  logic        standby_sleep, debug_halt, irq, wrap_event, compare_event;
  int          bad_count, checks_done, n_wrap, n_cmp;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [15:0] v;

  rtc_counter_core #(.ADDR_W(6)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ulp_32k_tick(tk[0]), .ulp_1k_tick(tk[1]), .crystal_tick(tk[2]),
    .ext_pin_tick(tk[3]), .standby_sleep(standby_sleep),
    .debug_halt(debug_halt), .irq(irq), .wrap_event(wrap_event),
    .compare_event(compare_event));

  // ====================================================================
  // Clock and shared helpers
  // ====================================================================
  always #2 aclk = ~aclk;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("Counts: %0d mismatches, %0d comparisons", bad_count,
             checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic give_up;
    bad_count++;
    $display("[FAIL] %0t handshake wait ran out", $time);
    conclude();
  endtask : give_up

  // Monitor: each answer pops the oldest note, so order errors show too
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) check(34'h3FFFFFFFF, 34'h0);
      else check({rresp, rdata}, rq.pop_front());
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) check(34'h3FFFFFFFF, 34'h0);
      else check({32'h0, bresp}, {32'h0, bq.pop_front()});
    end
    if (wrap_event) n_wrap++;
    if (compare_event) n_cmp++;
  end

  // ====================================================================
  // Bus and timebase tasks
  // ====================================================================
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] idx, input logic [7:0] d,
                    input logic [1:0] er = `RESP_OKAY);
    bq.push_back(er);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [7:0] d,
                    input logic [1:0] er = `RESP_OKAY);
    rq.push_back({er, 24'h0, d});
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask : rd

  // Low byte first: it loads the high byte into the scratch latch
  task automatic rd16(input logic [3:0] idx, input logic [15:0] d);
    rd(idx, d[7:0]);
    rd(idx + 4'h1, d[15:8]);
  endtask : rd16

  // One-cycle pulses on one source, spaced so busy bits settle
  task automatic tick(input int src, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      tk[src] <= 1'b1;
      @(posedge aclk);
      tk[src] <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask : tick

  // ====================================================================
  // Main sequence
  // ====================================================================
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awaddr = '0; araddr = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; wdata = '0; wstrb = 4'hF; tk = 4'h0;
    standby_sleep = 1'b0; debug_halt = 1'b1;
    bad_count = 0; checks_done = 0; n_wrap = 0; n_cmp = 0;
    void'($urandom(32'h3D37));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;

    // Reset values of every index; 6, E and F are unmapped
    for (int i = 0; i < 16; i++) begin
      if (i == 6 || i > 13) rd(i[3:0], 8'h00, `RESP_SLVERR);
      else rd(i[3:0], (i == 10 || i == 11) ? 8'hFF : 8'h00);
    end
    wr(4'h6, 8'h55, `RESP_SLVERR);
    wr(4'hE, 8'h55, `RESP_SLVERR);
    $display("Test reset and map done");

    // Read-as-zero bits and the directly usable scratch latch
    wr(`IDX_IRQ_ENABLE, 8'hFF);
    rd(`IDX_IRQ_ENABLE, 8'h03);
    wr(`IDX_SCRATCH, 8'h5A);
    rd(`IDX_SCRATCH, 8'h5A);
    $display("Test register access done");

    // All four busy bits raised by the three high-byte writes and the control write, cleared after two ticks
    wr(`IDX_WRAP_LO, 8'h05);
    wr(`IDX_WRAP_HI, 8'h00);
    wr(`IDX_COMPARE_LO, 8'h04);
    wr(`IDX_COMPARE_HI, 8'h00);
    wr(`IDX_COUNT_LO, 8'h03);
    wr(`IDX_COUNT_HI, 8'h00);
    wr(`IDX_CONTROL, 8'h87);
    rd(`IDX_STATUS, 8'h0F);
    rd(`IDX_CONTROL, 8'h81);
    tick(0, 2);
    rd(`IDX_STATUS, 8'h00);
    wr(`IDX_CONTROL, 8'h01);
    tick(0, 2);
    $display("Test sync busy done");

    // Halt released: 3 -> 4 (compare) -> 5 -> 0 (wrap)
    wr(`IDX_IRQ_ENABLE, 8'h01);
    n_wrap = 0;
    n_cmp = 0;
    debug_halt <= 1'b0;
    tick(0, 3);
    rd16(`IDX_COUNT_LO, 16'h0000);
    rd(`IDX_IRQ_FLAGS, 8'h03);
    check(n_wrap, 1);
    check(n_cmp, 1);
    check(irq, 1'b1);
    wr(`IDX_IRQ_FLAGS, 8'h01);
    rd(`IDX_IRQ_FLAGS, 8'h02);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
    wr(`IDX_IRQ_ENABLE, 8'h02);
    repeat (2) @(posedge aclk);
    check(irq, 1'b1);
    wr(`IDX_IRQ_FLAGS, 8'h02);
    rd(`IDX_IRQ_FLAGS, 8'h00);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
    $display("Test wrap and compare done");

    // Divide by four: eight ticks give exactly two steps at any phase
    debug_halt <= 1'b1;
    wr(`IDX_CONTROL, 8'h11);
    tick(0, 2);
    debug_halt <= 1'b0;
    tick(0, 8);
    rd16(`IDX_COUNT_LO, 16'h0002);
    // Standby stops the count unless standby-run is set
    standby_sleep <= 1'b1;
    tick(0, 8);
    rd16(`IDX_COUNT_LO, 16'h0002);
    debug_halt <= 1'b1;
    wr(`IDX_CONTROL, 8'h91);
    tick(0, 2);
    debug_halt <= 1'b0;
    tick(0, 8);
    rd16(`IDX_COUNT_LO, 16'h0004);
    standby_sleep <= 1'b0;
    $display("Test prescaler and standby done");

    // Only the selected source steps the count
    debug_halt <= 1'b1;
    wr(`IDX_CONTROL, 8'h01);
    tick(0, 2);
    debug_halt <= 1'b0;
    v = 16'h0004;
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_SOURCE, s[7:0]);
      for (int k = 0; k < 4; k++) tick(k, 1);
      v = (v == 16'h0005) ? 16'h0000 : v + 16'h0001;
      rd16(`IDX_COUNT_LO, v);
      rd(`IDX_SOURCE, s[7:0]);
    end
    // Keep-running bit lets the count go on under debug halt
    wr(`IDX_DEBUG, 8'h01);
    debug_halt <= 1'b1;
    tick(3, 1);
    rd16(`IDX_COUNT_LO, v + 16'h0001);
    wr(`IDX_DEBUG, 8'h00);
    tick(3, 1);
    rd16(`IDX_COUNT_LO, v + 16'h0001);
    $display("Test source and debug done");

    // Random count written through the scratch latch while halted
    v = 16'($urandom());
    wr(`IDX_COUNT_LO, v[7:0]);
    wr(`IDX_COUNT_HI, v[15:8]);
    rd(`IDX_STATUS, 8'h02);
    tick(3, 2);
    rd(`IDX_STATUS, 8'h00);
    rd16(`IDX_COUNT_LO, v);
    wr(`IDX_CONTROL, 8'h00);
    tick(3, 2);
    debug_halt <= 1'b0;
    tick(3, 2);
    rd16(`IDX_COUNT_LO, v);
    $display("Test count write and disable done");
    repeat (4) @(posedge aclk);
    conclude();
  end

endmodule : tb_rtc_counter_core
